// file: rtl/dsi_map.svh
// dsi_map.svh - error codes, fixed arguments and timing counts of the status indicator
`ifndef DSI_MAP_SVH
`define DSI_MAP_SVH

// error codes
`define DSI_CODE_NONE 5'h00
`define DSI_CODE_BREAK 5'h04
`define DSI_CODE_REGCOM 5'h05
`define DSI_CODE_SYSTEM 5'h06
`define DSI_CODE_CYCLE 5'h07
`define DSI_CODE_PROGRAM 5'h09
`define DSI_CODE_CONFIG 5'h0A
`define DSI_CODE_FORMAT 5'h0E
`define DSI_CODE_COUNT 5'h0F
`define DSI_CODE_LENGTH 5'h10

// fixed arguments
`define DSI_ARG_INIT 8'h00
`define DSI_ARG_INTERNAL 8'h01
`define DSI_ARG_SWITCH 8'h02
`define DSI_ARG_ZERO 8'h00
`define DSI_ARG_CHECKSUM 8'h00
`define DSI_ARG_LIBRARY 8'h01

// flash timing in ns and derived cycles at 40 MHz
`define DSI_CLK_NS 25
`define DSI_ON_NS 250000000
`define DSI_OFF_NS 250000000
`define DSI_GAP_NS 1000000000
`define DSI_ON_CYC (`DSI_ON_NS / `DSI_CLK_NS)
`define DSI_OFF_CYC (`DSI_OFF_NS / `DSI_CLK_NS)
`define DSI_GAP_CYC (`DSI_GAP_NS / `DSI_CLK_NS)

`endif

// file: rtl/dsi_pkg.sv
// dsi_pkg.sv - types of the status indicator
package dsi_pkg;
  // fieldbus link states
  typedef enum logic [3:0] {
    DSI_FB_SEARCH = 4'h1,
    DSI_FB_WAIT = 4'h2,
    DSI_FB_EXCHANGE = 4'h4,
    DSI_FB_ERROR = 4'h8
  } dsi_fb_t;
  // flash sequencer states
  typedef enum logic [4:0] {
    DSI_SQ_IDLE = 5'h01,
    DSI_SQ_ON = 5'h02,
    DSI_SQ_OFF = 5'h04,
    DSI_SQ_GAP = 5'h08,
    DSI_SQ_PHASE = 5'h10
  } dsi_sq_t;
endpackage

// file: rtl/dsi_blinker.sv
// dsi_blinker.sv - flash counter that shows a count as a train of pulses
`timescale 1ns/100ps
`default_nettype none
`include "dsi_map.svh"
module dsi_blinker
  import dsi_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int TIME_W = 32,
  parameter logic [TIME_W-1:0] ON_CYC = TIME_W'(`DSI_ON_CYC),
  parameter logic [TIME_W-1:0] OFF_CYC = TIME_W'(`DSI_OFF_CYC),
  parameter logic [TIME_W-1:0] GAP_CYC = TIME_W'(`DSI_GAP_CYC)
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pulse counts, shown code first then argument
  input wire logic enable_i,
  input wire logic [CNT_W-1:0] first_i,
  input wire logic [CNT_W-1:0] second_i,
  // lamp
  output logic lamp_o
);
  import dsi_pkg::*;

  initial
  begin
    if (CNT_W < 1 || TIME_W < 2 || ON_CYC == '0 || OFF_CYC == '0 || GAP_CYC == '0)
    begin
      $error("dsi_blinker: bad parameters");
    end
  end

  dsi_sq_t st_ff, nxt_st;
  logic [TIME_W-1:0] tmr_ff, nxt_tmr;
  logic [CNT_W:0] left_ff, nxt_left;
  logic second_ff, nxt_second;
  logic lamp_ff, nxt_lamp;

  // ========================================
  // sequencer: gap, pulses of first, gap, pulses of second+1
  always_comb
  begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    nxt_left = left_ff;
    nxt_second = second_ff;
    nxt_lamp = 1'b0;
    case (st_ff)
      DSI_SQ_IDLE:
      begin
        if (enable_i)
        begin
          nxt_st = DSI_SQ_GAP;
          nxt_tmr = GAP_CYC;
          nxt_second = 1'b0;
        end
      end
      DSI_SQ_GAP:
      begin
        if (!enable_i)
        begin
          nxt_st = DSI_SQ_IDLE;
        end
        else if (tmr_ff <= TIME_W'(1))
        begin
          nxt_st = DSI_SQ_PHASE;
        end
        else
        begin
          nxt_tmr = tmr_ff - TIME_W'(1);
        end
      end
      DSI_SQ_PHASE:
      begin
        // argument shown as n+1 pulses so that zero stays visible
        nxt_left = second_ff ? ({1'b0, second_i} + (CNT_W+1)'(1)) : {1'b0, first_i};
        nxt_st = DSI_SQ_ON;
        nxt_tmr = ON_CYC;
        nxt_lamp = 1'b1;
        if (nxt_left == '0)
        begin
          nxt_st = DSI_SQ_GAP;
          nxt_tmr = GAP_CYC;
          nxt_second = ~second_ff;
          nxt_lamp = 1'b0;
        end
      end
      DSI_SQ_ON:
      begin
        nxt_lamp = 1'b1;
        if (tmr_ff <= TIME_W'(1))
        begin
          nxt_st = DSI_SQ_OFF;
          nxt_tmr = OFF_CYC;
          nxt_left = left_ff - (CNT_W+1)'(1);
          nxt_lamp = 1'b0;
        end
        else
        begin
          nxt_tmr = tmr_ff - TIME_W'(1);
        end
      end
      DSI_SQ_OFF:
      begin
        if (tmr_ff > TIME_W'(1))
        begin
          nxt_tmr = tmr_ff - TIME_W'(1);
        end
        else if (left_ff != '0)
        begin
          nxt_st = DSI_SQ_ON;
          nxt_tmr = ON_CYC;
          nxt_lamp = 1'b1;
        end
        else
        begin
          nxt_st = DSI_SQ_GAP;
          nxt_tmr = GAP_CYC;
          nxt_second = ~second_ff;
        end
      end
      default:
      begin
        nxt_st = DSI_SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_ff <= DSI_SQ_IDLE;
      tmr_ff <= '0;
      left_ff <= '0;
      second_ff <= 1'b0;
      lamp_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      left_ff <= nxt_left;
      second_ff <= nxt_second;
      lamp_ff <= nxt_lamp;
    end
  end

  assign lamp_o = lamp_ff;
endmodule
`default_nettype wire

// file: rtl/dsi_top.sv
// dsi_top.sv - diagnostic status indicator of the fieldbus slave controller
// How it works
// - code 4 arg 0: break after controller
// - further break: argument is last reachable terminal
// - code 5: register traffic failed, terminal argument
// - code 6 args 0,1,2: init, data, switch
// - code 7 arg 0 on overrun, held
// - code 9: arg 0 checksum, 1 library
// - code 10: terminal differs from boot configuration
// - code 14: terminal format invalid, position argument
// - code 15: terminal count mismatch
// - code 16: terminal data length mismatch
// - baud search: all three fieldbus lamps off
// - awaiting parameters: run and fault lit
// - data exchange: only run lit
// - fieldbus error: run on, diagnostic flashes
// - controller lamp follows program running
// - terminal error lamp off or flashing code
`timescale 1ns/100ps
`default_nettype none
`include "dsi_map.svh"
module dsi_top
  import dsi_pkg::*;
#(
  parameter int POS_W = 8,
  parameter int TIME_W = 32,
  parameter logic [TIME_W-1:0] ON_CYC = TIME_W'(`DSI_ON_CYC),
  parameter logic [TIME_W-1:0] OFF_CYC = TIME_W'(`DSI_OFF_CYC),
  parameter logic [TIME_W-1:0] GAP_CYC = TIME_W'(`DSI_GAP_CYC)
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // terminal bus fault events, one-cycle pulses
  input wire logic tb_break_i,
  input wire logic [POS_W-1:0] tb_last_pos_i,
  input wire logic tb_regcom_fail_i,
  input wire logic tb_config_diff_i,
  input wire logic tb_format_bad_i,
  input wire logic [POS_W-1:0] tb_pos_i,
  input wire logic tb_count_bad_i,
  input wire logic tb_length_bad_i,
  // controller fault events, one-cycle pulses
  input wire logic init_fail_i,
  input wire logic data_fault_i,
  input wire logic switch_changed_i,
  input wire logic cycle_overrun_i,
  input wire logic prog_checksum_i,
  input wire logic lib_fault_i,
  // fieldbus and program state, pin levels
  input wire logic baud_found_i,
  input wire logic data_exchange_i,
  input wire logic fb_error_i,
  input wire logic [4:0] fb_err_code_i,
  input wire logic [POS_W-1:0] fb_err_arg_i,
  input wire logic prog_running_i,
  // latched error, terminal bus or controller
  output logic err_valid_o,
  output logic [4:0] err_code_o,
  output logic [POS_W-1:0] err_arg_o,
  // lamps
  output logic run_indicator_o,
  output logic bus_fault_indicator_o,
  output logic diagnostic_indicator_o,
  output logic controller_indicator_o,
  output logic tb_error_indicator_o
);
  import dsi_pkg::*;

  initial
  begin
    if (POS_W < 5 || POS_W > 16)
    begin
      $error("dsi_top: POS_W out of range");
    end
  end

  // ========================================
  // pin synchronisers
  localparam int SW = POS_W + 9;
  logic [SW-1:0] s1_ff, s2_ff;
  logic [POS_W+4:0] w3_ff;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      w3_ff <= '0;
    end
    else
    begin
      s1_ff <= {baud_found_i, data_exchange_i, fb_error_i, prog_running_i, fb_err_code_i, fb_err_arg_i};
      s2_ff <= s1_ff;
      w3_ff <= s2_ff[POS_W+4:0];
    end
  end

  logic baud_s, xchg_s, fberr_s, run_s, word_ok;
  assign baud_s = s2_ff[SW-1];
  assign xchg_s = s2_ff[SW-2];
  assign fberr_s = s2_ff[SW-3];
  assign run_s = s2_ff[SW-4];
  assign word_ok = (s2_ff[POS_W+4:0] == w3_ff);

  // ========================================
  // error latch, first fault wins until reset
  logic valid_ff, nxt_valid;
  logic [4:0] code_ff, nxt_code;
  logic [POS_W-1:0] arg_ff, nxt_arg;

  function automatic logic [POS_W-1:0] dsi_arg(input logic [7:0] v);
    dsi_arg = POS_W'(v);
  endfunction

  always_comb
  begin
    nxt_valid = valid_ff;
    nxt_code = code_ff;
    nxt_arg = arg_ff;
    if (!valid_ff)
    begin
      nxt_valid = 1'b1;
      if (init_fail_i | data_fault_i | switch_changed_i)
      begin
        nxt_code = `DSI_CODE_SYSTEM;
        nxt_arg = init_fail_i ? dsi_arg(`DSI_ARG_INIT) :
          (data_fault_i ? dsi_arg(`DSI_ARG_INTERNAL) : dsi_arg(`DSI_ARG_SWITCH));
      end
      else if (prog_checksum_i)
      begin
        nxt_code = `DSI_CODE_PROGRAM;
        nxt_arg = dsi_arg(`DSI_ARG_CHECKSUM);
      end
      else if (lib_fault_i)
      begin
        nxt_code = `DSI_CODE_PROGRAM;
        nxt_arg = dsi_arg(`DSI_ARG_LIBRARY);
      end
      else if (tb_break_i)
      begin
        // last position 0 means the controller itself
        nxt_code = `DSI_CODE_BREAK;
        nxt_arg = tb_last_pos_i;
      end
      else if (tb_regcom_fail_i | tb_config_diff_i | tb_format_bad_i | tb_count_bad_i | tb_length_bad_i)
      begin
        nxt_arg = tb_pos_i;
        nxt_code = tb_regcom_fail_i ? `DSI_CODE_REGCOM :
          tb_config_diff_i ? `DSI_CODE_CONFIG :
          tb_format_bad_i ? `DSI_CODE_FORMAT :
          tb_count_bad_i ? `DSI_CODE_COUNT :
          `DSI_CODE_LENGTH;
      end
      else if (cycle_overrun_i)
      begin
        nxt_code = `DSI_CODE_CYCLE;
        nxt_arg = dsi_arg(`DSI_ARG_ZERO);
      end
      else
      begin
        nxt_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      valid_ff <= 1'b0;
      code_ff <= `DSI_CODE_NONE;
      arg_ff <= '0;
    end
    else
    begin
      valid_ff <= nxt_valid;
      code_ff <= nxt_code;
      arg_ff <= nxt_arg;
    end
  end

  // ========================================
  // fieldbus state
  dsi_fb_t fb_ff, nxt_fb;
  logic [4:0] fbc_ff, nxt_fbc;
  logic [POS_W-1:0] fba_ff, nxt_fba;

  always_comb
  begin
    nxt_fbc = fbc_ff;
    nxt_fba = fba_ff;
    if (!baud_s)
    begin
      nxt_fb = DSI_FB_SEARCH;
    end
    else if (fberr_s)
    begin
      nxt_fb = DSI_FB_ERROR;
      // a word still settling is not taken
      if (word_ok)
      begin
        nxt_fbc = s2_ff[POS_W+4:POS_W];
        nxt_fba = s2_ff[POS_W-1:0];
      end
    end
    else if (xchg_s)
    begin
      nxt_fb = DSI_FB_EXCHANGE;
    end
    else
    begin
      nxt_fb = DSI_FB_WAIT;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      fb_ff <= DSI_FB_SEARCH;
      fbc_ff <= '0;
      fba_ff <= '0;
    end
    else
    begin
      fb_ff <= nxt_fb;
      fbc_ff <= nxt_fbc;
      fba_ff <= nxt_fba;
    end
  end

  // ========================================
  // flash trains
  logic dia_lamp, tb_lamp;

  dsi_blinker #(
    .CNT_W(POS_W),
    .TIME_W(TIME_W),
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_dia_blink (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(fb_ff == DSI_FB_ERROR),
    .first_i(POS_W'(fbc_ff)),
    .second_i(fba_ff),
    .lamp_o(dia_lamp)
  );

  dsi_blinker #(
    .CNT_W(POS_W),
    .TIME_W(TIME_W),
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_tb_blink (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(valid_ff),
    .first_i(POS_W'(code_ff)),
    .second_i(arg_ff),
    .lamp_o(tb_lamp)
  );

  // ========================================
  // lamp outputs
  logic run_ff, nxt_run, bf_ff, nxt_bf, dia_ff, nxt_dia, plc_ff, nxt_plc, tbl_ff, nxt_tbl;

  always_comb
  begin
    nxt_run = 1'b0;
    nxt_bf = 1'b0;
    nxt_dia = 1'b0;
    case (fb_ff)
      DSI_FB_SEARCH:
      begin
        nxt_run = 1'b0;
      end
      DSI_FB_WAIT:
      begin
        nxt_run = 1'b1;
        nxt_bf = 1'b1;
      end
      DSI_FB_EXCHANGE:
      begin
        nxt_run = 1'b1;
      end
      DSI_FB_ERROR:
      begin
        nxt_run = 1'b1;
        nxt_dia = dia_lamp;
      end
      default:
      begin
        nxt_run = 1'b0;
      end
    endcase
    nxt_plc = run_s;
    nxt_tbl = valid_ff & tb_lamp;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      run_ff <= 1'b0;
      bf_ff <= 1'b0;
      dia_ff <= 1'b0;
      plc_ff <= 1'b0;
      tbl_ff <= 1'b0;
    end
    else
    begin
      run_ff <= nxt_run;
      bf_ff <= nxt_bf;
      dia_ff <= nxt_dia;
      plc_ff <= nxt_plc;
      tbl_ff <= nxt_tbl;
    end
  end

  assign err_valid_o = valid_ff;
  assign err_code_o = code_ff;
  assign err_arg_o = arg_ff;
  assign run_indicator_o = run_ff;
  assign bus_fault_indicator_o = bf_ff;
  assign diagnostic_indicator_o = dia_ff;
  assign controller_indicator_o = plc_ff;
  assign tb_error_indicator_o = tbl_ff;
endmodule
`default_nettype wire

// file: tb/dsi_top_chk.sv
// checker of the status indicator outputs
`timescale 1ns/100ps
`default_nettype none
module dsi_top_chk
  import dsi_pkg::*;
#(
  parameter int POS_W = 8
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // fault events
  input wire logic tb_break_i,
  input wire logic [POS_W-1:0] tb_last_pos_i,
  input wire logic tb_regcom_fail_i,
  input wire logic [POS_W-1:0] tb_pos_i,
  input wire logic init_fail_i,
  input wire logic data_fault_i,
  input wire logic switch_changed_i,
  input wire logic prog_checksum_i,
  input wire logic lib_fault_i,
  // pin levels
  input wire logic baud_found_i,
  input wire logic data_exchange_i,
  input wire logic fb_error_i,
  input wire logic prog_running_i,
  // outputs
  input wire logic err_valid_o,
  input wire logic [4:0] err_code_o,
  input wire logic [POS_W-1:0] err_arg_o,
  input wire logic run_indicator_o,
  input wire logic bus_fault_indicator_o,
  input wire logic diagnostic_indicator_o,
  input wire logic controller_indicator_o,
  input wire logic tb_error_indicator_o
);
  default clocking dcb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // events ranked above the terminal bus ones
  logic sys_ev;
  assign sys_ev = init_fail_i | data_fault_i | switch_changed_i | prog_checksum_i | lib_fault_i;
  // ==========
  // error latch
  init_latch_a: assert property (!err_valid_o && init_fail_i |=> err_valid_o && err_code_o == 5'h06 &&
    err_arg_o == '0) else $error("init failure not latched");
  break_arg_a: assert property (!err_valid_o && tb_break_i && !sys_ev |=> err_code_o == 5'h04 &&
    err_arg_o == $past(tb_last_pos_i)) else $error("break code or position wrong");
  regcom_arg_a: assert property (!err_valid_o && tb_regcom_fail_i && !sys_ev && !tb_break_i |=>
    err_code_o == 5'h05 && err_arg_o == $past(tb_pos_i)) else $error("register fault code wrong");
  err_hold_a: assert property (err_valid_o |=> err_valid_o && $stable(err_code_o) && $stable(err_arg_o))
    else $error("latched error changed");
  tb_lamp_a: assert property (!err_valid_o |-> !tb_error_indicator_o)
    else $error("terminal error lamp lit without error");
  // ==========
  // lamps
  search_a: assert property (!baud_found_i [*6] |-> !run_indicator_o && !bus_fault_indicator_o &&
    !diagnostic_indicator_o) else $error("lamps lit during baud search");
  await_a: assert property ((baud_found_i && !data_exchange_i && !fb_error_i) [*6] |-> run_indicator_o &&
    bus_fault_indicator_o && !diagnostic_indicator_o) else $error("waiting lamps wrong");
  exchange_a: assert property ((baud_found_i && data_exchange_i && !fb_error_i) [*6] |-> run_indicator_o &&
    !bus_fault_indicator_o && !diagnostic_indicator_o) else $error("exchange lamps wrong");
  fb_fault_a: assert property ((baud_found_i && data_exchange_i && fb_error_i) [*6] |-> run_indicator_o &&
    !bus_fault_indicator_o) else $error("fieldbus error lamps wrong");
  ctrl_lamp_a: assert property ($stable(prog_running_i) [*5] |-> controller_indicator_o == prog_running_i)
    else $error("controller lamp does not follow program");
  cover property ($rose(err_valid_o));
  cover property ($rose(diagnostic_indicator_o));
  cover property ($rose(tb_error_indicator_o));
endmodule

bind dsi_top dsi_top_chk #(.POS_W(POS_W)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .tb_break_i(tb_break_i), .tb_last_pos_i(tb_last_pos_i),
  .tb_regcom_fail_i(tb_regcom_fail_i), .tb_pos_i(tb_pos_i), .init_fail_i(init_fail_i),
  .data_fault_i(data_fault_i), .switch_changed_i(switch_changed_i), .prog_checksum_i(prog_checksum_i),
  .lib_fault_i(lib_fault_i), .baud_found_i(baud_found_i), .data_exchange_i(data_exchange_i),
  .fb_error_i(fb_error_i), .prog_running_i(prog_running_i), .err_valid_o(err_valid_o),
  .err_code_o(err_code_o), .err_arg_o(err_arg_o), .run_indicator_o(run_indicator_o),
  .bus_fault_indicator_o(bus_fault_indicator_o), .diagnostic_indicator_o(diagnostic_indicator_o),
  .controller_indicator_o(controller_indicator_o), .tb_error_indicator_o(tb_error_indicator_o));
`default_nettype wire

// file: tb/dsi_fb_master.sv
// fieldbus master model driving the link state pins
`timescale 1ns/100ps
`default_nettype none
module dsi_fb_master
(
  // clock and mode
  input wire logic clock_i,
  input wire logic [1:0] mode_i,
  // link pins
  output wire logic baud_found_o,
  output wire logic data_exchange_o,
  output wire logic fb_error_o,
  output wire logic [4:0] err_code_o,
  output wire logic [7:0] err_arg_o
);
  // mode: 0 no master, 1 parameterising, 2 exchange, 3 fault
  logic [1:0] mode_ff = 2'h0;
  always @(posedge clock_i)
    mode_ff <= #2 mode_i;
  assign baud_found_o = mode_ff != 2'h0;
  assign data_exchange_o = mode_ff[1];
  assign fb_error_o = mode_ff == 2'h3;
  assign err_code_o = 5'h02;
  assign err_arg_o = 8'h00;
endmodule
`default_nettype wire

// file: tb/test_diag_status_indicator.sv
// testbench of the diagnostic status indicator
`timescale 1ns/100ps
`default_nettype none
module test_diag_status_indicator;
  import dsi_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] ev = 12'h000;
  logic [7:0] last_pos = 8'h00;
  logic [7:0] pos = 8'h2A;
  logic prog = 1'b0;
  logic [1:0] mode = 2'h0;
  logic baud, exch, fberr, err_valid, run, bf, diagnostic_indicator, ctrl, tblamp;
  logic [4:0] fcode, code;
  logic [7:0] farg, arg;
  int fail_count = 0;
  int num_checks = 0;
  logic [4:0] ec [12] = '{5'h06, 5'h06, 5'h06, 5'h09, 5'h09, 5'h04, 5'h05, 5'h0A, 5'h0E, 5'h0F, 5'h10, 5'h07};
  logic [7:0] ea [12] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00, 8'h2A, 8'h2A, 8'h2A, 8'h2A, 8'h2A, 8'h00};
  always #12.5 clock_i = ~clock_i;
  // ==========
  // instances
  dsi_top #(.ON_CYC(32'h00000004), .OFF_CYC(32'h00000004), .GAP_CYC(32'h0000000A)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .tb_break_i(ev[5]), .tb_last_pos_i(last_pos),
    .tb_regcom_fail_i(ev[6]), .tb_config_diff_i(ev[7]), .tb_format_bad_i(ev[8]), .tb_pos_i(pos),
    .tb_count_bad_i(ev[9]), .tb_length_bad_i(ev[10]), .init_fail_i(ev[0]), .data_fault_i(ev[1]),
    .switch_changed_i(ev[2]), .cycle_overrun_i(ev[11]), .prog_checksum_i(ev[3]), .lib_fault_i(ev[4]),
    .baud_found_i(baud), .data_exchange_i(exch), .fb_error_i(fberr), .fb_err_code_i(fcode),
    .fb_err_arg_i(farg), .prog_running_i(prog), .err_valid_o(err_valid), .err_code_o(code),
    .err_arg_o(arg), .run_indicator_o(run), .bus_fault_indicator_o(bf), .diagnostic_indicator_o(diagnostic_indicator),
    .controller_indicator_o(ctrl), .tb_error_indicator_o(tblamp));
  dsi_fb_master fbm (.clock_i(clock_i), .mode_i(mode), .baud_found_o(baud), .data_exchange_o(exch),
    .fb_error_o(fberr), .err_code_o(fcode), .err_arg_o(farg));
  // ==========
  // helpers
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      #2;
    end
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic restart();
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    tick(1);
    ev = 12'h000;
  endtask
  task automatic rises(input int len, input bit dia_sel, output int cnt);
    logic prev;
    logic cur;
    cnt = 0;
    prev = dia_sel ? diagnostic_indicator : tblamp;
    repeat (len)
    begin
      tick(1);
      cur = dia_sel ? diagnostic_indicator : tblamp;
      if (cur === 1'b1 && prev !== 1'b1)
        cnt++;
      prev = cur;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_codes();
    for (int i = 0; i < 12; i++)
    begin
      restart();
      pulse(i);
      chk("valid", {7'h00, err_valid}, 8'h01);
      chk("code", {3'h0, code}, {3'h0, ec[i]});
      chk("arg", arg, ea[i]);
    end
    $display("codes test done");
  endtask
  task automatic t_hold();
    restart();
    last_pos = 8'h05;
    pulse(5);
    chk("break arg", arg, 8'h05);
    tick(1);
    pulse(0);
    tick(3);
    chk("held code", {3'h0, code}, 8'h04);
    restart();
    pulse(11);
    tick(1);
    pulse(0);
    tick(20);
    chk("warning code", {3'h0, code}, 8'h07);
    chk("warning arg", arg, 8'h00);
    last_pos = 8'h00;
    $display("hold test done");
  endtask
  task automatic t_fbus();
    logic [7:0] exp [3];
    int n;
    exp = '{8'h00, 8'h06, 8'h04};
    for (int m = 0; m < 3; m++)
    begin
      mode = 2'(m);
      tick(8);
      chk("fieldbus lamps", {5'h00, run, bf, diagnostic_indicator}, exp[m]);
    end
    mode = 2'h3;
    tick(8);
    chk("error lamps", {6'h00, run, bf}, 8'h02);
    for (n = 0; n < 100 && diagnostic_indicator !== 1'b1; n++)
      tick(1);
    chk("diag flash", {7'h00, diagnostic_indicator}, 8'h01);
    if (diagnostic_indicator !== 1'b1)
      give_verdict();
    // second pulse of code 2, then argument 0 as one pulse
    rises(40, 1'b1, n);
    chk("diag pulses", 8'(n), 8'h02);
    mode = 2'h0;
    $display("fieldbus test done");
  endtask
  task automatic t_ctrl();
    prog = 1'b1;
    tick(6);
    chk("controller on", {7'h00, ctrl}, 8'h01);
    prog = 1'b0;
    tick(6);
    chk("controller off", {7'h00, ctrl}, 8'h00);
    $display("controller test done");
  endtask
  task automatic t_tblamp();
    int n;
    restart();
    rises(20, 1'b0, n);
    chk("quiet lamp", 8'(n), 8'h00);
    pos = 8'h02;
    pulse(6);
    rises(52, 1'b0, n);
    chk("code pulses", 8'(n), 8'h05);
    rises(34, 1'b0, n);
    chk("arg pulses", 8'(n), 8'h03);
    pos = 8'h2A;
    $display("terminal lamp test done");
  endtask
  initial
  begin
    restart();
    t_codes();
    t_hold();
    t_fbus();
    t_ctrl();
    t_tblamp();
    give_verdict();
  end
endmodule
`default_nettype wire
